// File: hw/hms_pkg.sv
// Constants, types and states of the high-speed two-wire configuration slave
package hms_pkg;

	// Timing base and filter figures
	localparam int CLK_NS = 100;
	localparam int GLITCH_NS = 10;
	localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_SPIKE_NS = 100;
	localparam int RST_SPIKE_CYC = (RST_SPIKE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_VALID_NS = 500;
	localparam int RST_VALID_CYC = (RST_VALID_NS + CLK_NS - 1) / CLK_NS;

	// Address and byte layout
	localparam logic [5:0] ADDR_HI = 6'h36;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int RW_BIT = 0;

	// Configuration byte value after either reset
	localparam logic [7:0] CFG_RESET = 8'h00;

	typedef struct packed {
		logic scl;
		logic sda;
	} hms_line_t;

	typedef struct packed {
		logic [7:0] data;
		logic update;
	} hms_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_AACK,
		ST_WRITE,
		ST_WACK,
		ST_READ,
		ST_SKIP
	} hms_state_t;

endpackage

// File: hw/hms_slave.sv
// High-speed two-wire configuration slave with filtered reset input
`timescale 1ns/100ps
module hms_slave import hms_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Serial bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	// Pins
	input wire logic i_address_lsb_select_input,
	input wire logic i_cfg_rst_n,
	// Configuration
	output hms_cfg_t o_cfg
);

	function automatic logic addr_match(input logic [7:0] sh, input logic lsb);
		addr_match = (sh[7:1] == {ADDR_HI, lsb});
	endfunction

	hms_line_t s1_q, s2_q, filt_q, prev_q;
	logic [2:0] gcnt_q [2];
	logic a0_s1_q, a0_q;
	logic rn_s1_q, rn_q;
	logic [2:0] rcnt_q;
	logic rst_fire;
	hms_state_t state_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q, tx_q;
	logic oe_q;
	logic [7:0] cfg_q;
	logic upd_q;
	logic scl_rise, scl_fall, start_ev, stop_ev;

	// Two-flop synchronisers for every pin
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q <= '1;
			s2_q <= '1;
			a0_s1_q <= 1'b0;
			a0_q <= 1'b0;
			rn_s1_q <= 1'b1;
			rn_q <= 1'b1;
		end else begin
			s1_q <= '{scl: i_scl, sda: i_sda};
			s2_q <= s1_q;
			a0_s1_q <= i_address_lsb_select_input;
			a0_q <= a0_s1_q;
			rn_s1_q <= i_cfg_rst_n;
			rn_q <= rn_s1_q;
		end
	end

	// Per-line glitch filter: a new level must persist beyond the glitch time
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_filt
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					gcnt_q[g] <= 3'h0;
					filt_q[g] <= 1'b1;
				end else if (s2_q[g] == filt_q[g]) begin
					gcnt_q[g] <= 3'h0;
				end else if (gcnt_q[g] == 3'(GLITCH_CYC)) begin
					gcnt_q[g] <= 3'h0;
					filt_q[g] <= s2_q[g];
				end else begin
					gcnt_q[g] <= gcnt_q[g] + 3'h1;
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			prev_q <= '1;
		end else begin
			prev_q <= filt_q;
		end
	end

	// Edges and bus conditions on the filtered lines
	assign scl_rise = filt_q.scl & ~prev_q.scl;
	assign scl_fall = ~filt_q.scl & prev_q.scl;
	assign start_ev = filt_q.scl & prev_q.scl & prev_q.sda & ~filt_q.sda;
	assign stop_ev = filt_q.scl & prev_q.scl & ~prev_q.sda & filt_q.sda;

	// Reset pin: count low samples; short spikes never reach the threshold
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rcnt_q <= 3'h0;
		end else if (rn_q) begin
			rcnt_q <= 3'h0;
		end else if (rcnt_q != 3'(RST_VALID_CYC)) begin
			rcnt_q <= rcnt_q + 3'h1;
		end
	end
	assign rst_fire = ~rn_q && (rcnt_q == 3'(RST_VALID_CYC));

	// Bus protocol; the pad only ever pulls low, the bus is never mastered
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			oe_q <= 1'b0;
		end else if (start_ev) begin
			state_q <= ST_ADDR;
			cnt_q <= 4'h0;
			oe_q <= 1'b0;
		end else if (stop_ev) begin
			state_q <= ST_IDLE;
			oe_q <= 1'b0;
		end else begin
			case (state_q)
				ST_ADDR, ST_WRITE: begin
					if (scl_rise && cnt_q != BYTE_BITS) begin
						sh_q <= {sh_q[6:0], filt_q.sda};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == BYTE_BITS) begin
						cnt_q <= 4'h0;
						if (state_q == ST_WRITE) begin
							state_q <= ST_WACK;
							oe_q <= 1'b1;
						end else if (addr_match(sh_q, a0_q)) begin
							state_q <= ST_AACK;
							oe_q <= 1'b1;
						end else begin
							state_q <= ST_SKIP;
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						if (sh_q[RW_BIT]) begin
							state_q <= ST_READ;
							oe_q <= ~cfg_q[7];
							tx_q <= {cfg_q[6:0], 1'b0};
							cnt_q <= 4'h1;
						end else begin
							state_q <= ST_WRITE;
							oe_q <= 1'b0;
						end
					end
				end
				ST_READ: begin
					if (scl_fall) begin
						if (cnt_q == BYTE_BITS) begin
							state_q <= ST_SKIP;
							oe_q <= 1'b0;
						end else begin
							oe_q <= ~tx_q[7];
							tx_q <= {tx_q[6:0], 1'b0};
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				ST_WACK: begin
					if (scl_fall) begin
						state_q <= ST_SKIP;
						oe_q <= 1'b0;
					end
				end
				ST_IDLE, ST_SKIP: begin
					oe_q <= 1'b0;
				end
				default: begin
					state_q <= ST_IDLE;
					oe_q <= 1'b0;
				end
			endcase
		end
	end

	// Configuration byte: written byte applies at once, reset pin wins
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cfg_q <= CFG_RESET;
			upd_q <= 1'b0;
		end else if (rst_fire) begin
			cfg_q <= CFG_RESET;
			upd_q <= 1'b1;
		end else if (state_q == ST_WRITE && scl_fall && cnt_q == BYTE_BITS && !start_ev && !stop_ev) begin
			cfg_q <= sh_q;
			upd_q <= 1'b1;
		end else begin
			upd_q <= 1'b0;
		end
	end

	assign o_sda = 1'b0;
	assign o_sda_oe = oe_q;
	assign o_cfg = '{data: cfg_q, update: upd_q};

	a_drive_states: assert property (@(posedge i_clk) disable iff (i_rst)
		oe_q |-> (state_q == ST_AACK || state_q == ST_WACK || state_q == ST_READ))
		else $error("sda driven outside acknowledge or read");
	a_ack_match: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == ST_ADDR && scl_fall && cnt_q == BYTE_BITS && !start_ev && !stop_ev
		&& sh_q[7:1] == {ADDR_HI, a0_q}) |=> (oe_q && state_q == ST_AACK))
		else $error("own address not acknowledged");
	a_nack_other: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == ST_ADDR && scl_fall && cnt_q == BYTE_BITS && sh_q[7:1] != {ADDR_HI, a0_q})
		|=> !oe_q)
		else $error("foreign address acknowledged");
	a_write_store: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == ST_WRITE && scl_fall && cnt_q == BYTE_BITS && !start_ev && !stop_ev && !rst_fire)
		|=> (cfg_q == $past(sh_q) && upd_q && oe_q))
		else $error("written byte not applied");
	a_single_byte: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == ST_WACK && scl_fall && !start_ev && !stop_ev) |=> (state_q == ST_SKIP && !oe_q))
		else $error("second byte accepted");
	a_rst_valid: assert property (@(posedge i_clk) disable iff (i_rst)
		(!rn_q) [*6] |=> (cfg_q == CFG_RESET))
		else $error("long reset pulse ignored");
	a_rst_spike: assert property (@(posedge i_clk) disable iff (i_rst)
		rst_fire |-> (!$past(rn_q, 1) && !$past(rn_q, 2) && !$past(rn_q, 3) && !$past(rn_q, 4) && !$past(rn_q, 5)))
		else $error("reset spike changed configuration");
	a_glitch_filt: assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(filt_q.scl) |-> ($past(s2_q.scl) == filt_q.scl && $past(s2_q.scl, 2) == filt_q.scl))
		else $error("scl glitch passed the filter");
	a_hold_time: assert property (@(posedge i_clk) disable iff (i_rst)
		!(scl_fall || start_ev || stop_ev || state_q == ST_IDLE || state_q == ST_SKIP) |=> $stable(oe_q))
		else $error("sda changed away from falling clock");
	a_read_bit: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_q == ST_READ && scl_fall && cnt_q != BYTE_BITS && !start_ev && !stop_ev)
		|=> (oe_q == ~$past(tx_q[7])))
		else $error("read bit wrong");

endmodule

// File: verif/hms_master.sv
// Behavioural two-wire bus master for the configuration slave
`timescale 1ns/100ps
module hms_master (
	// Bus lines
	output logic o_scl,
	output logic o_sda,
	input wire logic i_sda
);
	// Both lines rest high between frames, clock stands still there
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic start();
		#400 o_sda = 1'b0;
		#400 o_scl = 1'b0;
	endtask
	task automatic stop();
		#200 o_sda = 1'b0;
		#400 o_scl = 1'b1;
		#400 o_sda = 1'b1;
		#400;
	endtask
	// 800 ns bit: 600 ns low outwaits the slave's hold delay, 200 ns high passes its filter
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#300 o_sda = d[i];
			#300 o_scl = 1'b1;
			#100 q[i] = i_sda;
			#100 o_scl = 1'b0;
		end
		#300 o_sda = 1'b1;
		#300 o_scl = 1'b1;
		#100 ack = ~i_sda;
		#100 o_scl = 1'b0;
	endtask
endmodule

// File: verif/test_hms_slave.sv
// Self-checking bench for the two-wire configuration slave
`timescale 1ns/100ps
module test_hms_slave import hms_pkg::*; ;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sel = 1'b0;
	logic pin_rst_n = 1'b1;
	logic scl, m_sda, sda_oe, sda_out;
	hms_cfg_t cfg;
	wire logic sda_w = m_sda & (sda_oe ? sda_out : 1'b1);
	int failures = 0;
	int checks = 0;
	logic [7:0] q;
	logic a1, a2, a3;
	always #50 clk = ~clk;
	hms_slave hms_slave_i (.i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda_w), .o_sda(sda_out),
		.o_sda_oe(sda_oe), .i_address_lsb_select_input(sel), .i_cfg_rst_n(pin_rst_n), .o_cfg(cfg));
	hms_master hms_master_i (.o_scl(scl), .o_sda(m_sda), .i_sda(sda_w));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic frame(input logic a0, input logic rw, input logic [7:0] d, output logic aa, output logic ad);
		hms_master_i.start();
		hms_master_i.xfer({ADDR_HI, a0, rw}, q, aa);
		hms_master_i.xfer(d, q, ad);
		hms_master_i.stop();
	endtask
	task automatic t_write();
		fork
			frame(1'b0, 1'b0, 8'ha5, a1, a2);
			begin
				// One-sample low pulse on data while the clock is high must not start a frame
				#8700 hms_master_i.o_sda = 1'b0;
				#100 hms_master_i.o_sda = 1'b1;
			end
		join
		chk(8'(a1), 8'h01);
		chk(8'(a2), 8'h01);
		chk(cfg.data, 8'ha5);
		$display("t_write done");
	endtask
	task automatic t_read();
		frame(1'b0, 1'b1, 8'hff, a1, a2);
		chk(8'(a1), 8'h01);
		chk(q, 8'ha5);
		$display("t_read done");
	endtask
	task automatic t_addr();
		sel = 1'b1;
		frame(1'b0, 1'b0, 8'h3c, a1, a2);
		chk(8'(a1), 8'h00);
		chk(8'(a2), 8'h00);
		chk(cfg.data, 8'ha5);
		hms_master_i.start();
		hms_master_i.xfer({ADDR_HI, 1'b1, 1'b0}, q, a1);
		hms_master_i.xfer(8'h3c, q, a2);
		hms_master_i.xfer(8'h77, q, a3);
		hms_master_i.stop();
		chk(8'(a1), 8'h01);
		chk(8'(a2), 8'h01);
		chk(8'(a3), 8'h00);
		chk(cfg.data, 8'h3c);
		sel = 1'b0;
		$display("t_addr done");
	endtask
	task automatic t_pin();
		pin_rst_n = 1'b0;
		@(negedge clk);
		pin_rst_n = 1'b1;
		repeat (10) @(negedge clk);
		chk(cfg.data, 8'h3c);
		pin_rst_n = 1'b0;
		repeat (3) @(negedge clk);
		pin_rst_n = 1'b1;
		repeat (10) @(negedge clk);
		chk(cfg.data, 8'h3c);
		pin_rst_n = 1'b0;
		repeat (10) @(negedge clk);
		chk(8'(cfg.update), 8'h01);
		chk(cfg.data, CFG_RESET);
		pin_rst_n = 1'b1;
		$display("t_pin done");
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (10) @(negedge clk);
		t_write();
		t_read();
		t_addr();
		t_pin();
		final_report();
	end
	// Tests need about 80 us; cut a hang well beyond that
	initial begin
		#2000000;
		failures++;
		final_report();
	end
endmodule
